// *** rtl/src_cap_if.sv ***
// Carrier between the register front end and the capture engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface src_cap_if #(parameter int unsigned IGN_W = 4, parameter int unsigned CNT_W = 8);
    import src_pkg::*;
    src_mode_t mode;
    logic [IGN_W-1:0] ignore_cnt;
    logic flag_reset;
    logic valid_edge;
    logic capture;
    logic [CNT_W-1:0] count;
    modport front (output mode, ignore_cnt, flag_reset, valid_edge, input capture, count);
    modport engine (input mode, ignore_cnt, flag_reset, valid_edge, output capture, count);
endinterface

// *** rtl/src_capture_engine.sv ***
// Capture engine: decides which valid reference transitions are acted on.
// Assumes valid_edge is a one-cycle pulse per accepted transition.
`timescale 1ns/10ps
module src_capture_engine
    import src_pkg::*;
#(
    parameter int unsigned IGN_W = SRC_IGN_W,
    parameter int unsigned CNT_W = SRC_CNT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    src_cap_if.engine cap
);
    typedef enum logic [1:0] {SRC_ST_IDLE, SRC_ST_SKIP, SRC_ST_DONE} src_state_t;

    src_state_t state_q;
    logic [IGN_W-1:0] skip_q;
    logic capture_q;
    logic [CNT_W-1:0] count_q;
    logic fire;

    // Disabled mode re-arms the one-shot, so a fresh skip count applies next time.
    always_comb begin
        fire = 1'b0;
        if (cap.valid_edge) begin
            if (cap.mode == SRC_MODE_CONT) begin
                fire = 1'b1;
            end else if (cap.mode == SRC_MODE_NSHOT && state_q == SRC_ST_SKIP &&
                         skip_q == '0) begin
                fire = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SRC_ST_IDLE;
            skip_q <= '0;
        end else if (cap.mode != SRC_MODE_NSHOT) begin
            state_q <= SRC_ST_IDLE;
            skip_q <= '0;
        end else begin
            unique case (state_q)
                SRC_ST_IDLE: begin
                    state_q <= SRC_ST_SKIP;
                    skip_q <= cap.ignore_cnt;
                end
                SRC_ST_SKIP: begin
                    if (fire) begin
                        state_q <= SRC_ST_DONE;
                    end else if (cap.valid_edge) begin
                        skip_q <= skip_q - 1'b1;
                    end
                end
                SRC_ST_DONE: begin
                    state_q <= SRC_ST_DONE;
                end
                default: begin
                    state_q <= SRC_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_q <= 1'b0;
        end else begin
            capture_q <= fire;
        end
    end

    // Clearing wins over a capture here, so a held flag reset really reads zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (cap.flag_reset) begin
            count_q <= '0;
        end else if (fire) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign cap.capture = capture_q;
    assign cap.count = count_q;
endmodule

// *** rtl/src_capture_top.sv ***
// Reference-capture control: APB registers, edge sampling, error flags, interrupt.
// Assumes sysref_in, setup_err_in and hold_err_in are synchronous to pclk.
//
// Behaviour
// - Flag-reset bit holds setup/hold flags cleared.
// - Polarity bit picks rising or falling transitions.
// - Mode field: off, continuous, N-shot.
// - Edge bit picks rising or falling clock sample.
// - N-shot skips ignore-count valid transitions first.
// - Ignore count is linear up to fifteen.
// - Eight-bit capture count, cleared by flag reset, wraps.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
module src_capture_top
    import src_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SRC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sysref_in,
    input wire logic setup_err_in,
    input wire logic hold_err_in,
    output logic sysref_capture,
    output logic duty_cycle_stabilizer_power_up,
    output logic duty_cycle_stabilizer_enable,
    output logic irq
);
    src_cap_if #(.IGN_W(SRC_IGN_W), .CNT_W(SRC_CNT_W)) cap ();

    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [1:0] stab_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [1:0] err_flags_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic samp_rise_q;
    logic samp_fall_q;
    logic samp_prev_q;
    logic valid_edge_q;
    logic cap_d1_q;

    logic [9:0] idx;
    logic mapped;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_val;
    logic [7:0] ctrl1_d;
    logic [7:0] ctrl2_d;
    logic [1:0] stab_d;
    logic samp_now;
    logic edge_hit;
    logic [2:0] irq_events;
    logic [2:0] irq_clear;

    assign idx = paddr[SRC_ADDR_W-1:2];

    always_comb begin
        unique case (idx)
            SRC_IDX_STAB, SRC_IDX_CTRL1, SRC_IDX_CTRL2, SRC_IDX_COUNT,
            SRC_IDX_FLAGS, SRC_IDX_IRQ_STAT, SRC_IDX_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // The answer comes one cycle into the access phase; read data is latched at that edge, and a write commits one edge later.
    assign wr_en = psel && penable && pready_q && pwrite && mapped;
    assign rd_en = psel && penable && !pready_q && !pwrite;

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (idx)
            SRC_IDX_STAB: rd_val[1:0] = stab_q;
            SRC_IDX_CTRL1: rd_val[7:0] = ctrl1_q;
            SRC_IDX_CTRL2: rd_val[7:0] = ctrl2_q;
            SRC_IDX_COUNT: rd_val[SRC_CNT_W-1:0] = cap.count;
            SRC_IDX_FLAGS: rd_val[1:0] = err_flags_q;
            SRC_IDX_IRQ_STAT: rd_val[2:0] = irq_stat_q;
            SRC_IDX_IRQ_MASK: rd_val[2:0] = irq_mask_q;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            if (rd_en) begin
                prdata_q <= rd_val;
            end
        end
    end

    // Reserved bits are kept at zero by the write masks.
    always_comb begin
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        stab_d = stab_q;
        if (wr_en && idx == SRC_IDX_CTRL1) begin
            ctrl1_d = pwdata[7:0] & SRC_CTRL1_WMASK;
            // Polarity may only change while the mode field is off; else the old value stays.
            if (ctrl1_q[SRC_MODE_LSB +: 2] != SRC_MODE_OFF) begin
                ctrl1_d[SRC_POL_BIT] = ctrl1_q[SRC_POL_BIT];
            end
        end
        if (wr_en && idx == SRC_IDX_CTRL2) begin
            ctrl2_d = pwdata[7:0] & SRC_CTRL2_WMASK;
        end
        if (wr_en && idx == SRC_IDX_STAB) begin
            stab_d[SRC_STAB_PWR_BIT] = pwdata[SRC_STAB_PWR_BIT];
            // An enable request without power is dropped rather than passed on.
            stab_d[SRC_STAB_EN_BIT] = pwdata[SRC_STAB_EN_BIT] &&
                                      pwdata[SRC_STAB_PWR_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_q <= SRC_CTRL1_RST;
            ctrl2_q <= SRC_CTRL2_RST;
            stab_q <= SRC_STAB_RST;
        end else begin
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            stab_q <= stab_d;
        end
    end

    // Falling-edge sample is retimed to the rising edge; it costs half a cycle of margin.
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_fall_q <= 1'b0;
        end else begin
            samp_fall_q <= sysref_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_rise_q <= 1'b0;
        end else begin
            samp_rise_q <= sysref_in;
        end
    end

    assign samp_now = ctrl1_q[SRC_EDGE_BIT] ? samp_fall_q : samp_rise_q;
    assign edge_hit = ctrl1_q[SRC_POL_BIT] ? (samp_prev_q && !samp_now)
                                           : (!samp_prev_q && samp_now);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_prev_q <= 1'b0;
            valid_edge_q <= 1'b0;
        end else begin
            samp_prev_q <= samp_now;
            valid_edge_q <= edge_hit;
        end
    end

    assign cap.mode = src_mode_t'(ctrl1_q[SRC_MODE_LSB +: 2]);
    assign cap.ignore_cnt = ctrl2_q[SRC_IGN_W-1:0];
    assign cap.flag_reset = ctrl1_q[SRC_FLAG_RST_BIT];
    assign cap.valid_edge = valid_edge_q;

    src_capture_engine #(.IGN_W(SRC_IGN_W), .CNT_W(SRC_CNT_W)) u_engine (
        .pclk(pclk),
        .presetn(presetn),
        .cap(cap)
    );

    // Setup and hold flags are sticky; the flag-reset bit holds them at zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_flags_q <= 2'h0;
        end else if (ctrl1_q[SRC_FLAG_RST_BIT]) begin
            err_flags_q <= 2'h0;
        end else begin
            err_flags_q <= err_flags_q | {hold_err_in, setup_err_in};
        end
    end

    assign irq_events = {hold_err_in && !ctrl1_q[SRC_FLAG_RST_BIT],
                         setup_err_in && !ctrl1_q[SRC_FLAG_RST_BIT],
                         cap.capture};
    assign irq_clear = (wr_en && idx == SRC_IDX_IRQ_STAT) ? pwdata[2:0] : 3'h0;

    // A new event in the cycle of its clear keeps the bit set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= SRC_IRQ_RST;
            irq_mask_q <= SRC_IRQ_RST;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clear) | irq_events;
            if (wr_en && idx == SRC_IDX_IRQ_MASK) begin
                irq_mask_q <= pwdata[2:0];
            end
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_d1_q <= 1'b0;
        end else begin
            cap_d1_q <= cap.capture;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign sysref_capture = cap_d1_q;
    assign duty_cycle_stabilizer_power_up = stab_q[SRC_STAB_PWR_BIT];
    assign duty_cycle_stabilizer_enable = stab_q[SRC_STAB_EN_BIT];
endmodule

// *** rtl/src_pkg.sv ***
// Shared constants for the reference-capture control block.
// Assumes a 32-bit APB register bus; register indices are word numbers.
package src_pkg;
    localparam int unsigned SRC_ADDR_W = 12;
    // Register indices; the byte address is four times the index.
    localparam logic [9:0] SRC_IDX_STAB = 10'h11c;
    localparam logic [9:0] SRC_IDX_CTRL1 = 10'h120;
    localparam logic [9:0] SRC_IDX_CTRL2 = 10'h121;
    localparam logic [9:0] SRC_IDX_COUNT = 10'h12a;
    localparam logic [9:0] SRC_IDX_FLAGS = 10'h12b;
    localparam logic [9:0] SRC_IDX_IRQ_STAT = 10'h130;
    localparam logic [9:0] SRC_IDX_IRQ_MASK = 10'h131;
    // Field positions.
    localparam int unsigned SRC_STAB_PWR_BIT = 0;
    localparam int unsigned SRC_STAB_EN_BIT = 1;
    localparam int unsigned SRC_FLAG_RST_BIT = 6;
    localparam int unsigned SRC_POL_BIT = 4;
    localparam int unsigned SRC_EDGE_BIT = 3;
    localparam int unsigned SRC_MODE_LSB = 1;
    localparam int unsigned SRC_IRQ_CAP_BIT = 0;
    localparam int unsigned SRC_IRQ_SETUP_BIT = 1;
    localparam int unsigned SRC_IRQ_HOLD_BIT = 2;
    // Values after reset.
    localparam logic [7:0] SRC_CTRL1_RST = 8'h00;
    localparam logic [7:0] SRC_CTRL2_RST = 8'h00;
    localparam logic [1:0] SRC_STAB_RST = 2'h0;
    localparam logic [2:0] SRC_IRQ_RST = 3'h0;
    // Writable bits of each control register.
    localparam logic [7:0] SRC_CTRL1_WMASK = 8'h5e;
    localparam logic [7:0] SRC_CTRL2_WMASK = 8'h0f;
    localparam int unsigned SRC_IGN_W = 4;
    localparam int unsigned SRC_CNT_W = 8;
    typedef enum logic [1:0] {
        SRC_MODE_OFF = 2'h0,
        SRC_MODE_CONT = 2'h1,
        SRC_MODE_NSHOT = 2'h2,
        SRC_MODE_RSVD = 2'h3
    } src_mode_t;
endpackage

// *** verification/src_capture_checker.sv ***
// Assertions on the ports of the reference-capture block.
// Assumes one pclk domain with presetn as asynchronous active-low reset.
`timescale 1ns/10ps
module src_capture_checker
    import src_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SRC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sysref_in,
    input wire logic setup_err_in,
    input wire logic hold_err_in,
    input wire logic sysref_capture,
    input wire logic duty_cycle_stabilizer_power_up,
    input wire logic duty_cycle_stabilizer_enable,
    input wire logic irq
);
    logic [5:0] hist_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_q <= 6'h00;
        end else begin
            hist_q <= {hist_q[4:0], sysref_in};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_access: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready stood too long");
    a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside a transfer");
    a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_stab_power_first: assert property (duty_cycle_stabilizer_enable |->
        duty_cycle_stabilizer_power_up) else $error("stabilizer enabled unpowered");
    a_stab_write_only: assert property ($changed(duty_cycle_stabilizer_enable) |->
        $past(psel && penable && pready && pwrite)) else $error("enable moved alone");
    a_capture_single: assert property (sysref_capture |=> !sysref_capture)
        else $error("capture pulse too long");
    a_capture_has_cause: assert property (sysref_capture |->
        hist_q[5:1] != 5'h00 && hist_q[5:1] != 5'h1f) else $error("capture without edge");
    c_capture: cover property (sysref_capture);
    c_refused: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule
bind src_capture_top src_capture_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sysref_in(sysref_in), .setup_err_in(setup_err_in),
    .hold_err_in(hold_err_in), .sysref_capture(sysref_capture),
    .duty_cycle_stabilizer_power_up(duty_cycle_stabilizer_power_up),
    .duty_cycle_stabilizer_enable(duty_cycle_stabilizer_enable), .irq(irq));

// *** verification/src_refgen_model.sv ***
// Far-side model: drives the reference level and the two error events.
// Assumes one pclk; outputs change only just after rising edges.
`timescale 1ns/10ps
module src_refgen_model (
    input wire logic pclk,
    output logic sysref_in,
    output logic setup_err_in,
    output logic hold_err_in
);
    initial begin
        sysref_in = 1'h0;
        setup_err_in = 1'h0;
        hold_err_in = 1'h0;
    end
    // Each level stands four cycles, so every transition is seen cleanly.
    task automatic pulse(input int n);
        repeat (2 * n) begin
            @(posedge pclk);
            sysref_in <= ~sysref_in;
            repeat (3) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
    endtask
    task automatic err(input logic s, input logic h);
        @(posedge pclk);
        setup_err_in <= s;
        hold_err_in <= h;
        @(posedge pclk);
        setup_err_in <= 1'h0;
        hold_err_in <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask
endmodule

// *** verification/sysref_capture_control_tb.sv ***
// Self-checking bench: APB register tasks plus reference and error stimulus.
// Assumes the far-side model and the bound checker.
`timescale 1ns/10ps
module sysref_capture_control_tb;
    import src_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [SRC_ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sysref_in, setup_err_in, hold_err_in, err_seen;
    logic sysref_capture, duty_cycle_stabilizer_power_up, duty_cycle_stabilizer_enable, irq;
    int errors = 0, cmp_count = 0, caps = 0, cyc = 0;
    int ign[3] = '{0, 10, 15};
    src_capture_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sysref_in(sysref_in), .setup_err_in(setup_err_in),
        .hold_err_in(hold_err_in), .sysref_capture(sysref_capture),
        .duty_cycle_stabilizer_power_up(duty_cycle_stabilizer_power_up),
        .duty_cycle_stabilizer_enable(duty_cycle_stabilizer_enable), .irq(irq));
    src_refgen_model gen (.pclk(pclk), .sysref_in(sysref_in), .setup_err_in(setup_err_in),
        .hold_err_in(hold_err_in));
    always #12.5 pclk = ~pclk;
    always @(negedge pclk) if (sysref_capture === 1'h1) caps++;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Ready and read data are taken at the rising edge that completes the access.
    task automatic apb(input logic [9:0] idx, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err_seen = pslverr;
        if (n >= 20) errors++;
        psel <= 1'h0;
        penable <= 1'h0;
        // Outputs launched by the completing edge are looked at only once they settle.
        @(negedge pclk);
    endtask
    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        apb(idx, 1'h0, 32'h0);
        check(rd, exp);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        rd_chk(SRC_IDX_CTRL1, 32'h0);
        rd_chk(SRC_IDX_CTRL2, 32'h0);
        rd_chk(10'h000, 32'h0);
        check({31'h0, err_seen}, 32'h1);
        apb(SRC_IDX_STAB, 1'h1, 32'h2);
        rd_chk(SRC_IDX_STAB, 32'h0);
        apb(SRC_IDX_STAB, 1'h1, 32'h1);
        apb(SRC_IDX_STAB, 1'h1, 32'h3);
        check({30'h0, duty_cycle_stabilizer_power_up, duty_cycle_stabilizer_enable},
              32'h3);
        apb(SRC_IDX_CTRL1, 1'h1, 32'hff);
        rd_chk(SRC_IDX_CTRL1, 32'h5e);
        apb(SRC_IDX_CTRL1, 1'h1, 32'h0);
        rd_chk(SRC_IDX_CTRL1, 32'h10);
        apb(SRC_IDX_CTRL2, 1'h1, 32'hff);
        rd_chk(SRC_IDX_CTRL2, 32'h0f);
        apb(SRC_IDX_IRQ_MASK, 1'h1, 32'h7);
        // Polarity and edge in all four pairs, then modes off and reserved.
        for (int k = 0; k < 8; k++) begin
            apb(SRC_IDX_CTRL1, 1'h1, 32'h0);
            apb(SRC_IDX_CTRL1, 1'h1, (k & 3) << 3 | (k < 4 ? 2 : (k < 6 ? 0 : 6)));
            caps = 0;
            gen.pulse(2);
            check(caps, k < 4 ? 2 : 0);
        end
        rd_chk(SRC_IDX_COUNT, 32'h8);
        check({31'h0, irq}, 32'h1);
        apb(SRC_IDX_IRQ_STAT, 1'h1, 32'h7);
        rd_chk(SRC_IDX_IRQ_STAT, 32'h0);
        check({31'h0, irq}, 32'h0);
        foreach (ign[i]) begin
            apb(SRC_IDX_CTRL1, 1'h1, 32'h0);
            apb(SRC_IDX_CTRL2, 1'h1, ign[i]);
            apb(SRC_IDX_CTRL1, 1'h1, 32'h4);
            caps = 0;
            gen.pulse(ign[i] + 3);
            check(caps, 1);
        end
        apb(SRC_IDX_CTRL1, 1'h1, 32'h40);
        gen.err(1'h1, 1'h1);
        rd_chk(SRC_IDX_FLAGS, 32'h0);
        rd_chk(SRC_IDX_COUNT, 32'h0);
        apb(SRC_IDX_IRQ_STAT, 1'h1, 32'h7);
        apb(SRC_IDX_CTRL1, 1'h1, 32'h0);
        gen.err(1'h1, 1'h0);
        rd_chk(SRC_IDX_FLAGS, 32'h1);
        rd_chk(SRC_IDX_IRQ_STAT, 32'h2);
        check({31'h0, irq}, 32'h1);
        apb(SRC_IDX_IRQ_MASK, 1'h1, 32'h0);
        rd_chk(SRC_IDX_IRQ_MASK, 32'h0);
        check({31'h0, irq}, 32'h0);
        apb(SRC_IDX_CTRL1, 1'h1, 32'h2);
        gen.pulse(257);
        apb(SRC_IDX_CTRL1, 1'h1, 32'h0);
        rd_chk(SRC_IDX_COUNT, 32'h1);
        end_of_test();
    end
endmodule
